/* File: tei_core.sv */
// Trap pending flag, port edge interrupts and illegal condition detection.
//
// Behaviour
// - Device reset clears the trap pending flag.
// - A non-maskable trap sets the trap pending flag to one.
// - Only the clear-trap instruction or reset clears the trap pending flag.
// - The trap pending flag has no register address at all.
// - Fetching opcode 00 into the instruction register raises a software trap.
// - Reads of unused program memory return zero, hence trap on execution.
// - A software trap leaves the global interrupt enable unchanged.
// - Trap pending blocks other interrupts and steers dispatch to trap slot.
// - A trap routine can be interrupted only by another trap.
// - A software trap is taken at once, above every other source.
// - The pushed return address of a trap is the trap opcode address.
// - Eight selectable edge interrupts on the port share one vector.
// - A per-pin enable register gates each pin, shared with wake-up.
// - A per-pin edge select chooses rising or falling trigger.
// - A per-pin pending register latches edges; no other pending flag.
// - Port request needs both port master enable and global enable.
// - Wake with interrupt off resumes after halt; with it, routine first.
// - A maskable interrupt never preempts a routine already running.
// - A maskable routine can still be preempted by the trap.
// - Stack pointer decrements on call, entry or push; increments on pop.
// - Reset sets the stack pointer to 02F.
// - RAM 030 to 03F reads all ones, so over-pop returns to 7FFF.
// - Dispatch with trap active selects slot FE and FF.
// - The port interrupt uses the slot at E2 and E3.
`timescale 1ns/1ns
`default_nettype none

module tei_core #(
    parameter logic [14:0] PROG_TOP = tei_pkg::PROG_TOP_DEFAULT
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET,
    // Wishbone slave.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Instruction fetch and execution events from the core.
    input wire logic FETCH_LOAD,
    input wire logic [7:0] FETCH_OPCODE,
    input wire logic [14:0] FETCH_ADDR,
    input wire logic CLR_TRAP_EXEC,
    input wire logic VIS_EXEC,
    input wire logic IRQ_ENTRY,
    input wire logic RETURN_FROM_IRQ_INSTR_EXEC,
    input wire logic HALTED,
    // Higher ranked maskable sources, arbitrated outside.
    input wire logic EXT_MASK_REQ,
    input wire logic [7:0] EXT_MASK_VEC,
    // Interrupt outputs to the core.
    output logic TRAP_REQ,
    output logic [14:0] TRAP_RET_ADDR,
    output logic MASK_IRQ_REQ,
    output logic [7:0] VIS_OFFSET,
    output logic WAKE,
    output logic WAKE_TO_ISR,
    // Program memory read filter.
    input wire logic [14:0] PROG_ADDR,
    input wire logic [7:0] PROG_RAW,
    output logic [7:0] PROG_DATA,
    // Data memory read filter.
    input wire logic [7:0] RAM_ADDR,
    input wire logic [7:0] RAM_RAW,
    output logic [7:0] RAM_DATA,
    // Stack pointer control.
    input wire logic SP_PUSH,
    input wire logic SP_POP,
    output logic [7:0] SP,
    // Port pins.
    input wire logic [7:0] PORT_PIN
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic trap_pending_flag_reg;
    logic trap_req_reg;
    logic [14:0] trap_addr_reg;
    logic global_irq_enable_reg;
    logic port_irq_master_enable_reg;
    logic [7:0] wake_irq_enable_reg;
    logic [7:0] wake_edge_select_reg;
    logic [7:0] wake_pending_reg;
    logic [7:0] wake_pending_next;
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    logic [7:0] pin_prev_reg;
    logic [7:0] edge_hit;
    logic [7:0] sp_reg;
    logic [7:0] vis_offset_reg;
    logic wake_reg;
    logic wake_isr_reg;
    logic [7:0] prog_data_reg;
    logic [7:0] ram_data_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic trap_fetch;
    logic port_active;
    logic port_req;
    logic bus_req;
    logic bus_wr;
    logic [7:0] wr_byte;
    logic [7:0] pend_clear;

    // Bus request decode: one aligned word per register, lane 0 only.
    assign bus_req = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign bus_wr = bus_req & WB_WE_I & WB_SEL_I[0];
    assign wr_byte = WB_DAT_I[7:0];

    // ----------------------------------------------------------------
    // Software trap
    // ----------------------------------------------------------------

    // A trap opcode loaded into the instruction register is a trap.
    assign trap_fetch = FETCH_LOAD & (FETCH_OPCODE == tei_pkg::TRAP_OPCODE);

    // Hidden pending flag; a new trap wins over a clear in the same cycle.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            trap_pending_flag_reg <= 1'b0;
        end else if (trap_fetch) begin
            trap_pending_flag_reg <= 1'b1;
        end else if (CLR_TRAP_EXEC) begin
            trap_pending_flag_reg <= 1'b0;
        end
    end

    // Trap request is raised with no masking, so it is taken at once.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            trap_req_reg <= 1'b0;
            trap_addr_reg <= 15'h0000;
        end else begin
            trap_req_reg <= trap_fetch;
            if (trap_fetch) begin
                trap_addr_reg <= FETCH_ADDR;
            end
        end
    end

    assign TRAP_REQ = trap_req_reg;
    assign TRAP_RET_ADDR = trap_addr_reg;

    // ----------------------------------------------------------------
    // Control register: global enable and port master enable
    // ----------------------------------------------------------------

    // Entry into a maskable routine drops the global enable so no other
    // maskable source preempts it; the return sets it again. A trap is
    // not a maskable entry and leaves the bit alone.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            global_irq_enable_reg <= tei_pkg::CTRL_BIT_RESET;
            port_irq_master_enable_reg <= tei_pkg::CTRL_BIT_RESET;
        end else begin
            if (IRQ_ENTRY & ~trap_req_reg) begin
                global_irq_enable_reg <= 1'b0;
            end else if (RETURN_FROM_IRQ_INSTR_EXEC) begin
                global_irq_enable_reg <= 1'b1;
            end else if (bus_wr && WB_ADR_I == tei_pkg::OFS_CTRL) begin
                global_irq_enable_reg <= wr_byte[tei_pkg::CTRL_GIE_BIT];
            end
            if (bus_wr && WB_ADR_I == tei_pkg::OFS_CTRL) begin
                port_irq_master_enable_reg <=
                    wr_byte[tei_pkg::CTRL_PORT_EN_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Port edge interrupts
    // ----------------------------------------------------------------

    // Two-stage synchroniser, then a third stage for edge detection.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
            pin_prev_reg <= 8'h00;
        end else begin
            pin_meta_reg <= PORT_PIN;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Select bit high picks the falling edge, low the rising edge.
    assign edge_hit = (wake_edge_select_reg & pin_prev_reg & ~pin_sync_reg)
        | (~wake_edge_select_reg & ~pin_prev_reg & pin_sync_reg);

    // Enable and edge select registers.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wake_irq_enable_reg <= tei_pkg::BYTE_RESET;
            wake_edge_select_reg <= tei_pkg::BYTE_RESET;
        end else begin
            if (bus_wr && WB_ADR_I == tei_pkg::OFS_WAKE_EN) begin
                wake_irq_enable_reg <= wr_byte;
            end
            if (bus_wr && WB_ADR_I == tei_pkg::OFS_WAKE_EDGE) begin
                wake_edge_select_reg <= wr_byte;
            end
        end
    end

    // Writing ones clears pending bits; a fresh edge wins over the clear.
    assign pend_clear = (bus_wr && WB_ADR_I == tei_pkg::OFS_WAKE_PEND) ?
        wr_byte : 8'h00;

    always_comb begin
        wake_pending_next = (wake_pending_reg & ~pend_clear) | edge_hit;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            wake_pending_reg <= tei_pkg::BYTE_RESET;
        end else begin
            wake_pending_reg <= wake_pending_next;
        end
    end

    // Any enabled pending pin is active; all pins share one request.
    assign port_active = |(wake_pending_reg & wake_irq_enable_reg);
    assign port_req = port_active & port_irq_master_enable_reg
        & global_irq_enable_reg;

    // Maskable request, suppressed while the trap is pending.
    assign MASK_IRQ_REQ = (port_req | (EXT_MASK_REQ & global_irq_enable_reg))
        & ~trap_pending_flag_reg;

    // ----------------------------------------------------------------
    // Vectored dispatch offset
    // ----------------------------------------------------------------

    // Trap first, then outside sources, then the port, else the default.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            vis_offset_reg <= tei_pkg::VEC_DEFAULT;
        end else if (VIS_EXEC) begin
            if (trap_pending_flag_reg) begin
                vis_offset_reg <= tei_pkg::VEC_TRAP;
            end else if (EXT_MASK_REQ) begin
                vis_offset_reg <= EXT_MASK_VEC;
            end else if (port_active & port_irq_master_enable_reg) begin
                vis_offset_reg <= tei_pkg::VEC_PORT;
            end else begin
                vis_offset_reg <= tei_pkg::VEC_DEFAULT;
            end
        end
    end

    assign VIS_OFFSET = vis_offset_reg;

    // ----------------------------------------------------------------
    // Wake-up from halt or idle
    // ----------------------------------------------------------------

    // Wake pulse; the flag says whether the routine runs before resuming.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wake_reg <= 1'b0;
            wake_isr_reg <= 1'b0;
        end else begin
            wake_reg <= HALTED & port_active & ~wake_reg;
            if (HALTED & port_active & ~wake_reg) begin
                wake_isr_reg <= port_req;
            end
        end
    end

    assign WAKE = wake_reg;
    assign WAKE_TO_ISR = wake_isr_reg;

    // ----------------------------------------------------------------
    // Illegal condition detection on memory reads
    // ----------------------------------------------------------------

    // Unused program memory reads as the trap opcode.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            prog_data_reg <= tei_pkg::PROG_HOLE_DATA;
        end else if (PROG_ADDR > PROG_TOP) begin
            prog_data_reg <= tei_pkg::PROG_HOLE_DATA;
        end else begin
            prog_data_reg <= PROG_RAW;
        end
    end

    // The undefined RAM hole reads as all ones.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ram_data_reg <= tei_pkg::BYTE_RESET;
        end else if (RAM_ADDR >= tei_pkg::RAM_HOLE_LO
                     && RAM_ADDR <= tei_pkg::RAM_HOLE_HI) begin
            ram_data_reg <= tei_pkg::RAM_HOLE_DATA;
        end else begin
            ram_data_reg <= RAM_RAW;
        end
    end

    assign PROG_DATA = prog_data_reg;
    assign RAM_DATA = ram_data_reg;

    // Stack pointer; a bus write reloads it for recovery after a trap.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sp_reg <= tei_pkg::SP_RESET;
        end else if (bus_wr && WB_ADR_I == tei_pkg::OFS_STACK) begin
            sp_reg <= wr_byte;
        end else if (SP_PUSH & ~SP_POP) begin
            sp_reg <= sp_reg - 8'h01;
        end else if (SP_POP & ~SP_PUSH) begin
            sp_reg <= sp_reg + 8'h01;
        end
    end

    assign SP = sp_reg;

    // ----------------------------------------------------------------
    // Wishbone answer
    // ----------------------------------------------------------------

    // One-cycle acknowledge with read data; unmapped words read zero.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= 32'h0000_0000;
            if (bus_req & ~WB_WE_I) begin
                if (WB_ADR_I == tei_pkg::OFS_CTRL) begin
                    dat_reg[tei_pkg::CTRL_GIE_BIT] <= global_irq_enable_reg;
                    dat_reg[tei_pkg::CTRL_PORT_EN_BIT] <=
                        port_irq_master_enable_reg;
                end else if (WB_ADR_I == tei_pkg::OFS_WAKE_EN) begin
                    dat_reg[7:0] <= wake_irq_enable_reg;
                end else if (WB_ADR_I == tei_pkg::OFS_WAKE_EDGE) begin
                    dat_reg[7:0] <= wake_edge_select_reg;
                end else if (WB_ADR_I == tei_pkg::OFS_WAKE_PEND) begin
                    dat_reg[7:0] <= wake_pending_reg;
                end else if (WB_ADR_I == tei_pkg::OFS_STACK) begin
                    dat_reg[7:0] <= sp_reg;
                end
            end
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    // Trap fetch sets the flag on the next edge.
    property p_trap_set;
        @(posedge CLK) disable iff (RESET)
        trap_fetch |=> trap_pending_flag_reg;
    endproperty
    a_trap_set: assert property (p_trap_set)
        else $error("Trap fetch did not set the pending flag.");

    // The flag falls only after a clear instruction.
    property p_trap_clear_only;
        @(posedge CLK) disable iff (RESET)
        $fell(trap_pending_flag_reg) |-> $past(CLR_TRAP_EXEC);
    endproperty
    a_trap_clear_only: assert property (p_trap_clear_only)
        else $error("Trap pending flag cleared without clear instruction.");

    // Flag is zero right after reset.
    property p_trap_reset;
        @(posedge CLK) $past(RESET) |-> !trap_pending_flag_reg;
    endproperty
    a_trap_reset: assert property (p_trap_reset)
        else $error("Trap pending flag not cleared by reset.");

    // No maskable request while the trap is pending.
    property p_trap_blocks;
        @(posedge CLK) disable iff (RESET)
        trap_pending_flag_reg |-> !MASK_IRQ_REQ;
    endproperty
    a_trap_blocks: assert property (p_trap_blocks)
        else $error("Maskable request raised while trap pending.");

    // Dispatch during a pending trap yields slot FE.
    property p_vis_trap;
        @(posedge CLK) disable iff (RESET)
        (VIS_EXEC && trap_pending_flag_reg) |=> VIS_OFFSET == 8'hFE;
    endproperty
    a_vis_trap: assert property (p_vis_trap)
        else $error("Dispatch did not select the trap slot.");

    // Trap return address is the opcode address.
    property p_trap_addr;
        @(posedge CLK) disable iff (RESET)
        trap_fetch |=> TRAP_REQ && TRAP_RET_ADDR == $past(FETCH_ADDR);
    endproperty
    a_trap_addr: assert property (p_trap_addr)
        else $error("Trap return address is not the opcode address.");

    // A trap does not alter the global enable.
    property p_gie_kept;
        @(posedge CLK) disable iff (RESET)
        (trap_fetch && !IRQ_ENTRY && !RETURN_FROM_IRQ_INSTR_EXEC && !bus_wr)
        |=> $stable(global_irq_enable_reg);
    endproperty
    a_gie_kept: assert property (p_gie_kept)
        else $error("Trap changed the global enable.");

    // Port request needs both enables and an enabled pending pin.
    property p_port_gate;
        @(posedge CLK) disable iff (RESET)
        MASK_IRQ_REQ && !EXT_MASK_REQ |->
        global_irq_enable_reg && port_irq_master_enable_reg
        && |(wake_pending_reg & wake_irq_enable_reg);
    endproperty
    a_port_gate: assert property (p_port_gate)
        else $error("Port request without its enables.");

    // A synchronised rising edge on pin 0, set to rising, sets its pending bit.
    property p_edge_latch;
        @(posedge CLK) disable iff (RESET)
        (!wake_edge_select_reg[0] && pin_sync_reg[0] && !pin_prev_reg[0])
        |=> wake_pending_reg[0];
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("Rising edge on pin 0 was not latched.");

    // Over-popped stack region reads as all ones.
    property p_ram_hole;
        @(posedge CLK) disable iff (RESET)
        (RAM_ADDR >= 8'h30 && RAM_ADDR <= 8'h3F) |=> RAM_DATA == 8'hFF;
    endproperty
    a_ram_hole: assert property (p_ram_hole)
        else $error("RAM hole did not read as ones.");

    // A lone push moves the stack pointer down by one.
    property p_sp_push;
        @(posedge CLK) disable iff (RESET)
        (SP_PUSH && !SP_POP && !bus_wr) |=> SP == $past(SP) - 8'h01;
    endproperty
    a_sp_push: assert property (p_sp_push)
        else $error("Push did not decrement the stack pointer.");

endmodule

`default_nettype wire

/* File: tei_pkg.sv */
// Package of constants shared by the trap and edge interrupt logic.
package tei_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets on the Wishbone slave
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAKE_EN = 8'h04;
    localparam logic [7:0] OFS_WAKE_EDGE = 8'h08;
    localparam logic [7:0] OFS_WAKE_PEND = 8'h0C;
    localparam logic [7:0] OFS_STACK = 8'h10;

    // ----------------------------------------------------------------
    // Field positions of the control register
    // ----------------------------------------------------------------
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_PORT_EN_BIT = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] SP_RESET = 8'h2F;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic CTRL_BIT_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Opcodes, vector slots and memory ranges
    // ----------------------------------------------------------------
    localparam logic [7:0] TRAP_OPCODE = 8'h00;
    localparam logic [7:0] VEC_TRAP = 8'hFE;
    localparam logic [7:0] VEC_PORT = 8'hE2;
    localparam logic [7:0] VEC_DEFAULT = 8'hE0;
    localparam logic [7:0] RAM_HOLE_LO = 8'h30;
    localparam logic [7:0] RAM_HOLE_HI = 8'h3F;
    localparam logic [7:0] RAM_HOLE_DATA = 8'hFF;
    localparam logic [7:0] PROG_HOLE_DATA = 8'h00;
    localparam logic [14:0] PROG_TOP_DEFAULT = 15'h7FFE;

endpackage

/* File: tei_pins.sv */
// Model of the external devices that drive edges onto the port pins.
`timescale 1ns/1ns
`default_nettype none

module tei_pins (
    // Pin levels requested by the bench.
    input wire logic [7:0] lvl,
    // Port pins seen by the block.
    output logic [7:0] pin
);
    // Pins start low, before the bench asks for any level.
    initial pin = 8'h00;

    // Edges land out of phase with the core clock, as real pins would.
    always @(lvl) begin
        pin <= #3 lvl;
    end
endmodule

`default_nettype wire

/* File: tei_core_tb.sv */
// Self-checking bench for the trap and edge interrupt logic.
`timescale 1ns/1ns
`default_nettype none

module tei_core_tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic fl = 1'b0, clr = 1'b0, vectored_dispatch_instr = 1'b0, halt = 1'b0, emr = 1'b0;
    logic ent = 1'b0;
    logic push = 1'b0, pop = 1'b0, ack, treq, mreq, wake, wisr;
    logic [7:0] adr = 8'h00, op = 8'h00, emv = 8'h00, ra = 8'h00;
    logic [7:0] lvl = 8'h00, voff, pdat, rdat, sp, pin;
    logic [14:0] fa = 15'h0000, pa = 15'h0000, tra;
    logic [31:0] wdat = 32'h00000000, dat_o, rd;
    logic [7:0] rt [4] = '{8'h2F, 8'h30, 8'h3F, 8'h40};
    int error_cnt = 0, checked = 0, cyc_cnt = 0, i, j;

    // Clock of 100 MHz.
    always #5 clk = ~clk;

    // A hang is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            final_report;
        end
    end

    tei_core #(.PROG_TOP(15'h7FFE)) uut (.CLK(clk), .RESET(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .FETCH_LOAD(fl), .FETCH_OPCODE(op), .FETCH_ADDR(fa),
        .CLR_TRAP_EXEC(clr), .VIS_EXEC(vectored_dispatch_instr), .IRQ_ENTRY(ent),
        .RETURN_FROM_IRQ_INSTR_EXEC(1'b0), .HALTED(halt), .EXT_MASK_REQ(emr),
        .EXT_MASK_VEC(emv), .TRAP_REQ(treq), .TRAP_RET_ADDR(tra),
        .MASK_IRQ_REQ(mreq), .VIS_OFFSET(voff), .WAKE(wake),
        .WAKE_TO_ISR(wisr), .PROG_ADDR(pa), .PROG_RAW(8'hAB),
        .PROG_DATA(pdat), .RAM_ADDR(ra), .RAM_RAW(8'h5C), .RAM_DATA(rdat),
        .SP_PUSH(push), .SP_POP(pop), .SP(sp), .PORT_PIN(pin));

    tei_pins pins_i (.lvl(lvl), .pin(pin));

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic Wishbone cycle; read data lands in rd.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Reads a register and compares all 32 bits.
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(nm, {24'h000000, e}, rd);
    endtask

    // Core event: 0 fetch, 1 clear, 2 dispatch, 3 push, 4 pop, 5 entry.
    task automatic ev(input int k);
        @(posedge clk);
        fl <= (k == 0);
        clr <= (k == 1);
        vectored_dispatch_instr <= (k == 2);
        push <= (k == 3);
        pop <= (k == 4);
        ent <= (k == 5);
        @(posedge clk);
        {fl, clr, vectored_dispatch_instr, push, pop, ent} <= 6'h00;
        @(negedge clk);
    endtask

    // Moves the pins and lets the edge pass the synchroniser.
    task automatic pins(input logic [7:0] v);
        lvl <= v;
        repeat (6) @(negedge clk);
    endtask

    // Main sequence of scenarios.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("vis", 8'hE0, voff);
        rdc("sp_reg", tei_pkg::OFS_STACK, 8'h2F);
        rdc("unmapped", 8'h14, 8'h00);
        ev(3);
        chk("sp", 8'h2E, sp);
        ev(4);
        ev(4);
        chk("sp", 8'h30, sp);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            pa <= 15'h7FFC + 15'(i);
            ra <= rt[i];
            @(posedge clk);
            @(negedge clk);
            chk("prog", (i == 3) ? 8'h00 : 8'hAB, pdat);
            chk("ram", (rt[i] inside {[8'h30:8'h3F]}) ? 8'hFF : 8'h5C, rdat);
        end
        wb(1'b1, tei_pkg::OFS_CTRL, 8'h01);
        op <= 8'h5A;
        ev(0);
        chk("treq", 1'b0, treq);
        op <= 8'h00;
        fa <= 15'h1234;
        ev(0);
        chk("treq", 1'b1, treq);
        chk("ret", 15'h1234, tra);
        rdc("ctrl", tei_pkg::OFS_CTRL, 8'h01);
        emr <= 1'b1;
        emv <= 8'hF4;
        ev(2);
        chk("vis", 8'hFE, voff);
        ev(1);
        ev(2);
        chk("vis", 8'hF4, voff);
        emr <= 1'b0;
        // Pin 1 falls to trigger, pin 0 rises to trigger.
        wb(1'b1, tei_pkg::OFS_WAKE_EDGE, 8'h02);
        wb(1'b1, tei_pkg::OFS_WAKE_EN, 8'h03);
        pins(8'h02);
        pins(8'h03);
        rdc("pend", tei_pkg::OFS_WAKE_PEND, 8'h01);
        wb(1'b1, tei_pkg::OFS_WAKE_PEND, 8'h01);
        rdc("pend", tei_pkg::OFS_WAKE_PEND, 8'h00);
        pins(8'h01);
        pins(8'h00);
        rdc("pend", tei_pkg::OFS_WAKE_PEND, 8'h02);
        pins(8'h01);
        for (i = 0; i < 4; i++) begin
            wb(1'b1, tei_pkg::OFS_CTRL, 8'(i));
            chk("mreq", i == 3, mreq);
        end
        ev(2);
        chk("vis", 8'hE2, voff);
        for (i = 0; i < 2; i++) begin
            wb(1'b1, tei_pkg::OFS_CTRL, (i == 1) ? 8'h03 : 8'h02);
            halt <= 1'b1;
            for (j = 0; j < 20 && wake !== 1'b1; j++) @(negedge clk);
            chk("wake", 1'b1, wake);
            chk("wisr", i == 1, wisr);
            halt <= 1'b0;
            @(negedge clk);
        end
        wb(1'b1, tei_pkg::OFS_WAKE_EN, 8'h00);
        chk("mreq", 1'b0, mreq);
        wb(1'b1, tei_pkg::OFS_WAKE_EN, 8'h02);
        chk("mreq", 1'b1, mreq);
        ev(0);
        chk("mreq", 1'b0, mreq);
        ev(0);
        chk("treq", 1'b1, treq);
        ev(2);
        chk("vis", 8'hFE, voff);
        ev(1);
        chk("mreq", 1'b1, mreq);
        ev(5);
        rdc("ctrl", tei_pkg::OFS_CTRL, 8'h02);
        chk("mreq", 1'b0, mreq);
        // A reset in mid-run with the trap pending.
        ev(0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("sp", 8'h2F, sp);
        rdc("ctrl", tei_pkg::OFS_CTRL, 8'h00);
        emr <= 1'b1;
        ev(2);
        chk("vis", 8'hF4, voff);
        final_report;
    end
endmodule

`default_nettype wire
